// *** pkg/hbf_regs.vh ***
// constants for the h-bridge fault and slew control block
`ifndef HBF_REGS_VH
`define HBF_REGS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define HBF_CLK_NS       8
`define HBF_DGL_NS       1000
`define HBF_DGL_CYC      ((`HBF_DGL_NS + `HBF_CLK_NS - 1) / `HBF_CLK_NS)
`define HBF_DEAD_BASE_NS 500
`define HBF_DEAD_STEP_NS 400
`define HBF_OCP_NS       3000
`define HBF_OCP_CYC      ((`HBF_OCP_NS + `HBF_CLK_NS - 1) / `HBF_CLK_NS)
`define HBF_WAKE_NS      1000
`define HBF_WAKE_CYC     ((`HBF_WAKE_NS + `HBF_CLK_NS - 1) / `HBF_CLK_NS)
`define HBF_RETRY_NS     4000000
`define HBF_RETRY_CYC    ((`HBF_RETRY_NS + `HBF_CLK_NS - 1) / `HBF_CLK_NS)

// ----------------------------------------
// register map
// ----------------------------------------
`define HBF_A_CTRL   8'h00
`define HBF_A_STAT   8'h04
`define HBF_A_SLEW   8'h08
`define HBF_C_SLEW   2:0
`define HBF_C_OCPM   4:3
`define HBF_C_CPDIS  5
`define HBF_C_CLR    6
`define HBF_C_MODE   8:7
`define HBF_CTRL_RST 9'h000
`define HBF_SYNC_RST 12'h200
`define HBF_RESP_OK  2'h0
`define HBF_RESP_ERR 2'h2

// ----------------------------------------
// encodings
// ----------------------------------------
`define HBF_OCP_LATCH  2'h0
`define HBF_OCP_RETRY  2'h1
`define HBF_OCP_REPORT 2'h2
`define HBF_OCP_OFF    2'h3
`define HBF_MODE_INDEP 2'h2
`define HBF_SR_FAST    3'h0
`define HBF_SR_MID     3'h3
`define HBF_SR_SLOW    3'h7

`endif

// *** verilog/hbf_fault_slew.v ***
// h-bridge drive sequencing, fault protection and register slave
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "hbf_regs.vh"

// Operation
// (R1) serial variant: slew code from register field
// (R2) strap tied low selects fastest slew
// (R3) strap floating mid, tied high slowest
// (R4) hold output high-impedance dead interval first
// (R5) dead interval grows with slower slew
// (R6) deglitch drive inputs before use
// (R7) conducting transistor off before another on
// (R8) fault line low while fault present
// (R9) fault line low until core ready
// (R10) sleep while sleep input low
// (R11) no readback data during sleep
// (R12) controller prefers clear bit over sleep
// (R13) supply undervoltage: outputs, pump off, latch
// (R14) supply undervoltage recovers; bit stays latched
// (R15) pump undervoltage: outputs off, latch, recover
// (R16) pump undervoltage ignored when disable set
// (R17) filtered overcurrent disables affected bridge; outside independent mode the code disables both bridges
// (R18) overcurrent mode reset default is latched
// (R19) latched mode: resume after clear, condition gone
// (R20) retry mode: resume after retry time
// (R21) report mode: keep driving, report until cleared
// (R22) independent mode handles bridges separately
// (R23) disabled mode ignores overcurrent
// (R24) release line only when nothing pending
module hbf_fault_slew #(
  parameter RETRY_CYC = `HBF_RETRY_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [1:0]  drive_inputs,
  input  wire        sleep_input_n,
  input  wire        serial_variant,
  input  wire        slew_pin_low,
  input  wire        slew_pin_high,
  input  wire        motor_supply_uv,
  input  wire        pump_voltage_uv,
  input  wire [3:0]  fet_overcurrent,
  output wire [1:0]  gate_high,
  output wire [1:0]  gate_low,
  output reg         pump_enable,
  output wire        fault_line_n_o,
  output reg         fault_line_n_oe,
  output reg  [2:0]  slew_code,
  output reg         sleep_active
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [8:0] dead_cyc;
    input [2:0] code;
    integer     ns;
    integer     cyc;
    begin
      ns       = `HBF_DEAD_BASE_NS + code * `HBF_DEAD_STEP_NS;
      cyc      = ((ns + `HBF_CLK_NS - 1) / `HBF_CLK_NS) - 1;
      dead_cyc = cyc[8:0];
    end
  endfunction

  localparam ST_OFF  = 2'h0;
  localparam ST_HS   = 2'h1;
  localparam ST_LS   = 2'h2;
  localparam ST_DEAD = 2'h3;

  localparam integer DGL_I    = `HBF_DGL_CYC - 1;
  localparam integer OCP_I    = `HBF_OCP_CYC - 1;
  localparam integer WAKE_I   = `HBF_WAKE_CYC - 1;
  localparam integer RTY_I    = RETRY_CYC - 1;
  localparam [7:0]   DGL_MAX  = DGL_I[7:0];
  localparam [8:0]   OCP_MAX  = OCP_I[8:0];
  localparam [7:0]   WAKE_MAX = WAKE_I[7:0];
  localparam [19:0]  RTY_MAX  = RTY_I[19:0];

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [11:0] meta_r;
  reg [11:0] sync_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      // sleep bit starts at its idle level: no false sleep after reset
      meta_r <= `HBF_SYNC_RST;
      sync_r <= `HBF_SYNC_RST;
    end else begin
      meta_r <= {drive_inputs, sleep_input_n, serial_variant,
                 slew_pin_low, slew_pin_high, motor_supply_uv,
                 pump_voltage_uv, fet_overcurrent};
      sync_r <= meta_r;
    end
  end

  wire [1:0] in_s    = sync_r[11:10];
  wire       awake_s = sync_r[9];
  wire       ser_s   = sync_r[8];
  wire       sr_lo_s = sync_r[7];
  wire       sr_hi_s = sync_r[6];
  wire       vm_uv_s = sync_r[5];
  wire       cp_uv_s = sync_r[4];
  wire [3:0] oc_s    = sync_r[3:0];

  // ----------------------------------------
  // registers and bus slave
  // ----------------------------------------
  reg  [8:0] ctrl_r;
  reg        clr_r;
  reg        core_rdy_r;
  reg        flt_sum_r;
  reg        vm_uv_lat_r;
  reg        cp_uv_lat_r;
  reg        ocp_lat_r;
  reg  [3:0] fet_lat_r;
  wire [1:0] oc_hold;
  wire [1:0] oc_off;

  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid;

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;

  wire [31:0] stat_w = {19'h00000, slew_code, sleep_active, core_rdy_r,
                        fet_lat_r, ocp_lat_r, cp_uv_lat_r, vm_uv_lat_r,
                        flt_sum_r};

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r       <= `HBF_CTRL_RST;
      clr_r        <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `HBF_RESP_OK;
    end else begin
      clr_r <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `HBF_RESP_ERR;
        if (s_axi_awaddr == `HBF_A_CTRL) begin
          s_axi_bresp <= `HBF_RESP_OK;
          if (s_axi_wstrb[0]) begin
            ctrl_r[5:0] <= s_axi_wdata[5:0];
            ctrl_r[7]   <= s_axi_wdata[7];
            clr_r       <= s_axi_wdata[`HBF_C_CLR];
          end
          if (s_axi_wstrb[1]) begin
            ctrl_r[8] <= s_axi_wdata[8];
          end
        end else if (s_axi_awaddr == `HBF_A_STAT ||
                     s_axi_awaddr == `HBF_A_SLEW) begin
          s_axi_bresp <= `HBF_RESP_OK;
        end
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `HBF_RESP_OK;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `HBF_RESP_OK;
        s_axi_rdata  <= 32'h00000000;
        if (sleep_active) begin
          s_axi_rresp <= `HBF_RESP_ERR;  // see (R11)
        end else if (s_axi_araddr == `HBF_A_CTRL) begin
          s_axi_rdata <= {23'h000000, ctrl_r};
        end else if (s_axi_araddr == `HBF_A_STAT) begin
          s_axi_rdata <= stat_w;
        end else if (s_axi_araddr == `HBF_A_SLEW) begin
          s_axi_rdata <= {23'h000000, dead_cyc(slew_code)};
        end else begin
          s_axi_rresp <= `HBF_RESP_ERR;
        end
      end
    end
  end

  // ----------------------------------------
  // sleep, wake-up and slew selection
  // ----------------------------------------
  reg  [7:0] wake_r;
  wire       core_rst = ~aresetn | ~awake_s;  // see (R10)

  always @(posedge aclk) begin
    if (core_rst) begin
      wake_r     <= 8'h00;
      core_rdy_r <= 1'b0;
    end else if (!core_rdy_r) begin
      wake_r <= wake_r + 8'h01;
      if (wake_r == WAKE_MAX) begin
        core_rdy_r <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      sleep_active <= 1'b0;
      slew_code    <= `HBF_SR_FAST;
    end else begin
      sleep_active <= ~awake_s;  // see (R10)
      if (ser_s) begin
        slew_code <= ctrl_r[`HBF_C_SLEW];  // see (R1)
      end else if (sr_lo_s) begin
        slew_code <= `HBF_SR_FAST;  // see (R2)
      end else if (sr_hi_s) begin
        slew_code <= `HBF_SR_SLOW;  // see (R3)
      end else begin
        slew_code <= `HBF_SR_MID;  // see (R3)
      end
    end
  end

  // ----------------------------------------
  // undervoltage and summary status
  // ----------------------------------------
  wire cp_uv_act = cp_uv_s & ~ctrl_r[`HBF_C_CPDIS];  // see (R16)
  wire [3:0] oc_det_w;
  wire oc_new    = |oc_det_w & (ctrl_r[`HBF_C_OCPM] != `HBF_OCP_OFF);

  always @(posedge aclk) begin
    if (core_rst) begin
      flt_sum_r   <= 1'b0;
      vm_uv_lat_r <= 1'b0;
      cp_uv_lat_r <= 1'b0;
      ocp_lat_r   <= 1'b0;
      fet_lat_r   <= 4'h0;
    end else begin
      // set wins over clear
      if (clr_r) begin
        flt_sum_r   <= 1'b0;
        vm_uv_lat_r <= 1'b0;  // see (R14)
        cp_uv_lat_r <= 1'b0;  // see (R15)
        ocp_lat_r   <= 1'b0;
        fet_lat_r   <= 4'h0;
      end
      if (vm_uv_s) begin
        vm_uv_lat_r <= 1'b1;  // see (R13)
        flt_sum_r   <= 1'b1;
      end
      if (cp_uv_act) begin
        cp_uv_lat_r <= 1'b1;  // see (R15)
        flt_sum_r   <= 1'b1;
      end
      if (oc_new) begin
        ocp_lat_r <= 1'b1;  // see (R19)
        flt_sum_r <= 1'b1;
        fet_lat_r <= (clr_r ? 4'h0 : fet_lat_r) | oc_det_w;
      end
    end
  end

  // ----------------------------------------
  // overcurrent filters, one per transistor
  // ----------------------------------------
  genvar f;
  generate
    for (f = 0; f < 4; f = f + 1) begin : g_ocf
      reg [8:0] cnt_r;
      always @(posedge aclk) begin
        if (core_rst || !oc_s[f]) begin
          cnt_r <= 9'h000;
        end else if (cnt_r != OCP_MAX) begin
          cnt_r <= cnt_r + 9'h001;
        end
      end
      assign oc_det_w[f] = oc_s[f] && (cnt_r == OCP_MAX);  // see (R17)
    end
  endgenerate

  // ----------------------------------------
  // overcurrent response, one per half-bridge
  // ----------------------------------------
  wire       indep  = (ctrl_r[`HBF_C_MODE] == `HBF_MODE_INDEP);
  wire [1:0] ocm    = ctrl_r[`HBF_C_OCPM];  // see (R18)
  wire [1:0] hb_oc  = {oc_det_w[3] | oc_det_w[2], oc_det_w[1] | oc_det_w[0]};
  wire       any_oc = |hb_oc;

  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1) begin : g_ocr
      reg        hold_r;
      reg [19:0] rty_r;
      // in independent mode only the faulted bridge trips
      wire hit  = indep ? hb_oc[b] : any_oc;  // see (R22)
      wire gone = indep ? ~hb_oc[b] : ~any_oc;
      always @(posedge aclk) begin
        if (core_rst) begin
          hold_r <= 1'b0;
          rty_r  <= 20'h00000;
        end else if (hit && ocm != `HBF_OCP_OFF) begin
          hold_r <= 1'b1;  // see (R23)
          rty_r  <= 20'h00000;
        end else if (hold_r) begin
          if (ocm == `HBF_OCP_RETRY) begin
            if (rty_r != RTY_MAX) begin
              rty_r <= rty_r + 20'h00001;
            end else if (gone) begin
              hold_r <= 1'b0;  // see (R20)
            end
          end else if (ocm == `HBF_OCP_OFF) begin
            hold_r <= 1'b0;
          end else if (clr_r && gone) begin
            hold_r <= 1'b0;  // see (R19) (R21)
          end
        end
      end
      assign oc_hold[b] = hold_r;
      // report mode keeps the bridge driving
      assign oc_off[b]  = hold_r && (ocm != `HBF_OCP_REPORT);  // see (R21)
    end
  endgenerate

  // ----------------------------------------
  // fault line and charge pump
  // ----------------------------------------
  assign fault_line_n_o = 1'b0;

  always @(posedge aclk) begin
    if (!aresetn) begin
      fault_line_n_oe <= 1'b1;
      pump_enable     <= 1'b0;
    end else begin
      // see (R8) (R9) (R24)
      fault_line_n_oe <= ~core_rdy_r | vm_uv_s | cp_uv_act | (|oc_hold);
      pump_enable     <= core_rdy_r & ~vm_uv_s;  // see (R13)
    end
  end

  // ----------------------------------------
  // deglitch and half-bridge sequencing
  // ----------------------------------------
  wire drive_ok = core_rdy_r & ~vm_uv_s & ~cp_uv_act;  // see (R13) (R15)

  generate
    for (b = 0; b < 2; b = b + 1) begin : g_hb
      reg [7:0] dgl_r;
      reg       in_r;
      reg [1:0] st_r;
      reg [8:0] dead_r;
      reg       tgt_r;

      always @(posedge aclk) begin
        if (core_rst) begin
          dgl_r <= 8'h00;
          in_r  <= 1'b0;
        end else if (in_s[b] == in_r) begin
          dgl_r <= 8'h00;
        end else if (dgl_r == DGL_MAX) begin
          in_r  <= in_s[b];  // see (R6)
          dgl_r <= 8'h00;
        end else begin
          dgl_r <= dgl_r + 8'h01;
        end
      end

      always @(posedge aclk) begin
        if (core_rst || !drive_ok || oc_off[b]) begin
          st_r   <= ST_OFF;  // see (R17)
          dead_r <= 9'h000;
          tgt_r  <= 1'b0;
        end else begin
          case (st_r)
            ST_OFF: begin
              st_r   <= ST_DEAD;
              tgt_r  <= in_r;
              dead_r <= dead_cyc(slew_code);
            end
            ST_HS: begin
              if (!in_r) begin
                st_r   <= ST_DEAD;  // see (R7)
                tgt_r  <= 1'b0;
                dead_r <= dead_cyc(slew_code);  // see (R5)
              end
            end
            ST_LS: begin
              if (in_r) begin
                st_r   <= ST_DEAD;  // see (R7)
                tgt_r  <= 1'b1;
                dead_r <= dead_cyc(slew_code);  // see (R5)
              end
            end
            ST_DEAD: begin
              if (dead_r != 9'h000) begin
                dead_r <= dead_r - 9'h001;  // see (R4)
              end else begin
                st_r <= tgt_r ? ST_HS : ST_LS;
              end
            end
            default: begin
              st_r <= ST_OFF;
            end
          endcase
        end
      end

      assign gate_high[b] = (st_r == ST_HS);
      assign gate_low[b]  = (st_r == ST_LS);
    end
  endgenerate

endmodule

`default_nettype wire

// *** test/hbf_stage_model.sv ***
// power stage stand-in that reports overcurrent on driven transistors
`timescale 1ns/100ps
`default_nettype none
module hbf_stage_model (
  input  wire logic [1:0] gate_high,
  input  wire logic [1:0] gate_low,
  input  wire logic [1:0] short_en,
  output logic      [3:0] fet_overcurrent
);
  // a shorted load draws current only through a transistor that is on
  assign fet_overcurrent = {short_en[1] ? {gate_low[1], gate_high[1]} : 2'h0,
                            short_en[0] ? {gate_low[0], gate_high[0]} : 2'h0};
endmodule
`default_nettype wire

// *** test/hbf_fault_slew_chk.sv ***
// assertion checker for the h-bridge fault and slew block
`timescale 1ns/100ps
`default_nettype none
`include "hbf_regs.vh"
module hbf_fault_slew_chk #(
  parameter RETRY_CYC = 20
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        sleep_input_n,
  input wire logic        serial_variant,
  input wire logic        slew_pin_low,
  input wire logic        slew_pin_high,
  input wire logic        motor_supply_uv,
  input wire logic [1:0]  gate_high,
  input wire logic [1:0]  gate_low,
  input wire logic        pump_enable,
  input wire logic        fault_line_n_oe,
  input wire logic [2:0]  slew_code,
  input wire logic        sleep_active
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_no_shoot; (gate_high & gate_low) == 2'h0; endproperty
  property p_dead; $fell(gate_low[0]) |=> !gate_high[0] [*8]; endproperty
  property p_wake; $rose(aresetn) |=> fault_line_n_oe [*8]; endproperty
  property p_uv;
    motor_supply_uv [*5] |-> !pump_enable && fault_line_n_oe && (gate_high | gate_low) == 2'h0;
  endproperty
  property p_sleep; !sleep_input_n [*5] |-> sleep_active && fault_line_n_oe; endproperty
  property p_rd_sleep;
    $rose(s_axi_rvalid) && $past(sleep_active) |->
      s_axi_rresp == `HBF_RESP_ERR && s_axi_rdata == 32'h0;
  endproperty
  property p_bresp; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid; endproperty
  property p_strap_lo;
    (!serial_variant && slew_pin_low && sleep_input_n) [*5] |-> slew_code == `HBF_SR_FAST;
  endproperty
  property p_strap_hi;
    (!serial_variant && !slew_pin_low && slew_pin_high && sleep_input_n) [*5] |->
      slew_code == `HBF_SR_SLOW;
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("both gates of a bridge on");
  a_dead: assert property (p_dead) else $error("dead interval too short");
  a_wake: assert property (p_wake) else $error("line released before core ready");
  a_uv: assert property (p_uv) else $error("supply undervoltage not acted on");
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  a_rd_sleep: assert property (p_rd_sleep) else $error("read data during sleep");
  a_bresp: assert property (p_bresp) else $error("write response late");
  a_strap_lo: assert property (p_strap_lo) else $error("grounded strap not fastest");
  a_strap_hi: assert property (p_strap_hi) else $error("high strap not slowest");
  c_write: cover property (s_axi_bvalid);
  c_release: cover property ($fell(fault_line_n_oe));
  c_drive: cover property ($rose(gate_high[0]));
endmodule
bind hbf_fault_slew hbf_fault_slew_chk #(.RETRY_CYC(RETRY_CYC)) u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_rvalid,
  .s_axi_rdata, .s_axi_rresp, .sleep_input_n, .serial_variant, .slew_pin_low,
  .slew_pin_high, .motor_supply_uv, .gate_high, .gate_low, .pump_enable,
  .fault_line_n_oe, .slew_code, .sleep_active);
`default_nettype wire

// *** test/tb_hbf_fault_slew.sv ***
// self-checking testbench for the h-bridge fault and slew block
`timescale 1ns/100ps
`default_nettype none
`include "hbf_regs.vh"
module tb_hbf_fault_slew;
  // ----------------------------------------
  // signals and helpers
  // ----------------------------------------
  localparam logic [1:0]  OK = `HBF_RESP_OK;
  localparam logic [1:0]  ER = `HBF_RESP_ERR;
  localparam logic [31:0] AL = 32'hFFFFFFFF;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, sleep_input_n, serial_variant;
  logic        slew_pin_low, slew_pin_high, motor_supply_uv, pump_voltage_uv;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, cv;
  logic [1:0]  drive_inputs, short_en;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         pump_enable, fault_line_n_oe, sleep_active, fault_line_n_o;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, gate_high, gate_low;
  wire  [31:0] s_axi_rdata;
  wire  [3:0]  fet_overcurrent;
  wire  [2:0]  slew_code;
  logic [65:0] expq[$];
  logic [65:0] e;
  logic [2:0]  rc;
  int          mismatches, cmp_count, cyc, bad;

  hbf_fault_slew #(.RETRY_CYC(20)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .drive_inputs, .sleep_input_n,
    .serial_variant, .slew_pin_low, .slew_pin_high, .motor_supply_uv, .pump_voltage_uv,
    .fet_overcurrent, .gate_high, .gate_low, .pump_enable, .fault_line_n_o,
    .fault_line_n_oe, .slew_code, .sleep_active);
  hbf_stage_model u_stage (.gate_high, .gate_low, .short_en, .fet_overcurrent);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic test_done();
    if (expq.size() != 0) mismatches++;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
    @(posedge aclk);
  endtask
  // the monitor compares each read against the oldest queued note
  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] m,
                    input logic [31:0] d);
    expq.push_back({er, m, d});
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wait_oe(input logic v, input int lim);
    int n;
    n = 0;
    while (fault_line_n_oe !== v && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  function automatic logic [31:0] dcyc(input logic [2:0] c);
    return (500 + 400 * c + 7) / 8 - 1;
  endfunction
  task automatic dead(input logic [2:0] c);
    int n, k;
    n = 0;
    k = 0;
    wr(`HBF_A_CTRL, {29'h0, c}, OK);
    rd(`HBF_A_SLEW, OK, AL, dcyc(c));
    drive_inputs <= 2'b00;
    tick(800);
    drive_inputs <= 2'b01;
    while (gate_low[0] !== 1'b0 && n < 300) begin
      tick(1);
      n++;
    end
    while (gate_high[0] !== 1'b1 && k < 600) begin
      tick(1);
      k++;
    end
    chk("in_delay", 1, n >= 125 && n <= 134);
    chk("dead", 1, k >= dcyc(c) && k <= dcyc(c) + 3);
  endtask

  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      e = expq.size() > 0 ? expq.pop_front() : {ER, AL, AL};
      chk("rresp", e[65:64], s_axi_rresp);
      chk("rdata", e[31:0], s_axi_rdata & e[63:32]);
    end
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      test_done();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {slew_pin_low, slew_pin_high, motor_supply_uv, pump_voltage_uv} = '0;
    {sleep_input_n, serial_variant} = 2'b11;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, drive_inputs, short_en} = '0;
    void'($urandom(34));
    tick(12);
    aresetn <= 1'b1;
    tick(2);
    chk("wake_hold", 1, fault_line_n_oe);
    wait_oe(1'b0, 300);
    chk("wake_release", 0, fault_line_n_oe);
    rd(`HBF_A_CTRL, OK, AL, {23'h0, `HBF_CTRL_RST});
    rc = 3'($urandom);
    wr(`HBF_A_CTRL, {29'h0, rc}, OK);
    tick(4);
    chk("slew_serial", rc, slew_code);
    rd(`HBF_A_STAT, OK, 32'h1C00, {19'h0, rc, 10'h0});
    rd(8'h0C, ER, AL, 32'h0);
    wr(8'h0C, $urandom, ER);
    $display("test registers done");
    serial_variant <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      {slew_pin_low, slew_pin_high} <= 2'(i);
      tick(6);
      chk("strap", i[1] ? `HBF_SR_FAST : i[0] ? `HBF_SR_SLOW : `HBF_SR_MID, slew_code);
    end
    serial_variant <= 1'b1;
    dead(3'h0);
    dead(rc);
    dead(3'h7);
    drive_inputs <= 2'b00;
    tick(60);
    drive_inputs <= 2'b01;
    bad = 0;
    repeat (300) begin
      tick(1);
      if (gate_high[0] !== 1'b1) bad++;
    end
    chk("glitch", 0, bad);
    $display("test drive done");
    motor_supply_uv <= 1'b1;
    tick(10);
    chk("uv_pump", 0, pump_enable);
    rd(`HBF_A_STAT, OK, 32'h7, 32'h3);
    motor_supply_uv <= 1'b0;
    wait_oe(1'b0, 50);
    chk("uv_release", 0, fault_line_n_oe);
    rd(`HBF_A_STAT, OK, 32'h2, 32'h2);
    wr(`HBF_A_CTRL, 32'h40, OK);
    rd(`HBF_A_STAT, OK, 32'h2, 32'h0);
    pump_voltage_uv <= 1'b1;
    tick(10);
    chk("pump_undervoltage_bit_line", 1, fault_line_n_oe);
    chk("line_level", 0, fault_line_n_o);
    chk("pump_undervoltage_bit_pump", 1, pump_enable);
    pump_voltage_uv <= 1'b0;
    wait_oe(1'b0, 50);
    chk("pump_undervoltage_bit_release", 0, fault_line_n_oe);
    wr(`HBF_A_CTRL, 32'h60, OK);
    pump_voltage_uv <= 1'b1;
    tick(10);
    chk("pump_undervoltage_bit_off", 0, fault_line_n_oe);
    rd(`HBF_A_STAT, OK, 32'h4, 32'h0);
    pump_voltage_uv <= 1'b0;
    $display("test undervoltage done");
    for (int m = 0; m < 5; m++) begin
      cv = {23'h0, m == 4 ? `HBF_MODE_INDEP : 2'h0, 2'h0, 2'(m % 4), 3'h0};
      wr(`HBF_A_CTRL, cv, OK);
      tick(800);
      short_en <= 2'b10;
      if (m == 3) tick(500);
      else wait_oe(1'b1, 600);
      tick(2);
      chk("ocp_line", m != 3, fault_line_n_oe);
      chk("ocp_gate", m >= 2, gate_high[0]);
      rd(`HBF_A_STAT, OK, 32'hF9, m == 3 ? 32'h0 : 32'h89);
      short_en <= 2'b00;
      tick(400);
      chk("ocp_hold", m % 2 == 0 && m != 4 || m == 4, fault_line_n_oe);
      chk("ocp_resume", m != 0, gate_high[0]);
      wr(`HBF_A_CTRL, cv | 32'h40, OK);
      tick(300);
      chk("ocp_clear", 0, fault_line_n_oe);
      chk("ocp_drive", 1, gate_high[0] & gate_low[1]);
    end
    $display("test overcurrent done");
    sleep_input_n <= 1'b0;
    tick(10);
    chk("sleep", 1, sleep_active);
    rd(`HBF_A_CTRL, ER, AL, 32'h0);
    sleep_input_n <= 1'b1;
    tick(20);
    chk("sleep_wake", 1, fault_line_n_oe);
    wait_oe(1'b0, 300);
    chk("sleep_ready", 0, fault_line_n_oe);
    $display("test sleep done");
    test_done();
  end
endmodule
`default_nettype wire
